/* tb/tb_ctf_timing.sv */
// Self-checking testbench of the processor timing facilities block
module tb_ctf_timing;
   timeunit 1ns;
   timeprecision 1ns;
   import ctf_pkg::*;

   // ************************************************************
   // Signals and bookkeeping
   // ************************************************************
   localparam int US = 4; // Short microsecond keeps the run brief
   localparam int ITV = 50;
   logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [AW-1:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, junk, i1, i3;
   logic pready, pslverr, sec_sw = 1'b0, sys_stop = 1'b0, ext_int, cc_pend, tmr_pend;
   logic [33:0] q[$];
   logic [33:0] ent;
   logic [51:0] c1, c2, t1, t2, v;
   int errors = 0, cmp_count = 0, cyc = 0, seed = 32'h6cfc, k1, k2, dc, dt;

   ctf_timing #(.US_CYC_P(US), .ITV_CYC_P(ITV)) dut (
      .sys_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .sec_sw_in(sec_sw),
      .sys_stop_in(sys_stop), .ext_int_out(ext_int), .cc_pend_out(cc_pend),
      .tmr_pend_out(tmr_pend));

   // Free-running clock and a cycle count for rate checks
   initial begin
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
   end

   // ************************************************************
   // Comparison and closing
   // ************************************************************
   task automatic chk(input logic [51:0] s, input logic [51:0] x);
      cmp_count++;
      if (s !== x) begin
         errors++;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic ok(input logic b);
      chk({51'h0, b}, 52'h1);
   endtask
   task automatic print_verdict();
      if (errors == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Monitor takes the oldest note whenever the slave answers
   always @(posedge clk) begin
      if (pready === 1'b1) begin
         if (q.size() == 0) begin
            ok(1'b0);
         end else begin
            ent = q.pop_front();
            chk({51'h0, pslverr}, {51'h0, ent[32]});
            if (ent[33]) chk({20'h0, prdata}, {20'h0, ent[31:0]});
         end
      end
   end

   // ************************************************************
   // Bus and pin tasks
   // ************************************************************
   // Request held until pready is sampled; a bounded wait avoids a hang
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic e, input logic c, input logic [31:0] x, output logic [31:0] r);
      int n;
      q.push_back({c, e, x});
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // A missing answer ends the run here, after the request is released
      if (n >= 20) begin
         errors++;
         print_verdict();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d, e, 1'b0, 32'h0, junk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, 1'b0, 1'b1, x, junk);
   endtask
   // High half first: it stages the upper bits that the low-half write then loads
   task automatic w52(input logic [7:0] a, input logic [51:0] d);
      wr(a, {12'h0, d[51:32]}, 1'b0);
      wr(a + 8'h04, d[31:0], 1'b0);
   endtask
   task automatic r52(input logic [7:0] a, input logic c, input logic [51:0] x,
      output logic [51:0] o);
      logic [31:0] h, l;
      apb(1'b0, a, 32'h0, 1'b0, c, {12'h0, x[51:32]}, h);
      apb(1'b0, a + 8'h04, 32'h0, 1'b0, c, x[31:0], l);
      o = {h[19:0], l};
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Pins pass a synchroniser, so allow it to settle
   task automatic pins(input logic s, input logic w);
      @(posedge clk);
      sys_stop <= s;
      sec_sw <= w;
      idle(6);
   endtask
   task automatic masks(input logic cc, input logic tm);
      for (int m = 0; m < 16; m++) begin
         wr(ADR_CTRL, 32'(m), 1'b0);
         idle(3);
         chk({51'h0, ext_int}, {51'h0, m[1] & ((cc & m[2]) | (tm & m[3]))});
      end
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      idle(10);
      rd(ADR_CTRL, 32'h0);
      // Timer steps below zero on the first tick, time of day passes zero
      rd(ADR_STAT, 32'h3);
      wr(ADR_STAT, 32'hf, 1'b0);
      rd(ADR_STAT, 32'h3);
      rd(ADR_CMD, 32'h0);
      apb(1'b0, 8'h28, 32'h0, 1'b1, 1'b0, 32'h0, junk);
      wr(8'hfc, 32'h1, 1'b1);
      for (logic [7:0] a = ADR_CMP_HI; a <= ADR_TMR_LO; a += 8'h04) begin
         wr(a, 32'h1, 1'b1);
         apb(1'b0, a, 32'h0, 1'b1, 1'b0, 32'h0, junk);
      end
      wr(ADR_TOD_LO, 32'h5, 1'b1);
      wr(ADR_CTRL, 32'h1, 1'b0);
      wr(ADR_TOD_HI, 32'h5, 1'b1);
      pins(1'b0, 1'b1);
      w52(ADR_TOD_HI, 52'hf_ffff_ffff_fffe);
      idle(40);
      r52(ADR_TOD_HI, 1'b0, 52'h0, v);
      ok(v < 52'd64);
      // Stopped system: readback of random loads, resets, frozen timers
      pins(1'b1, 1'b1);
      rd(ADR_STAT, 32'hf);
      for (int i = 0; i < 3; i++) begin
         v = 52'({$random(seed), $random(seed)});
         w52(ADR_TMR_HI, v);
         r52(ADR_TMR_HI, 1'b1, v, t1);
         v = 52'({$random(seed), $random(seed)});
         w52(ADR_CMP_HI, v);
         r52(ADR_CMP_HI, 1'b1, v, c1);
      end
      wr(ADR_CMD, 32'h2, 1'b0);
      r52(ADR_TMR_HI, 1'b1, 52'h0, t1);
      r52(ADR_CMP_HI, 1'b1, v, c1);
      w52(ADR_TMR_HI, v);
      wr(ADR_CMD, 32'h1, 1'b0);
      r52(ADR_CMP_HI, 1'b1, 52'h0, c1);
      wr(ADR_ITV, 32'h00abcd, 1'b0);
      r52(ADR_TOD_HI, 1'b0, 52'h0, c1);
      idle(60);
      rd(ADR_ITV, 32'h00abcd);
      r52(ADR_TMR_HI, 1'b1, 52'h0, t1);
      r52(ADR_TOD_HI, 1'b0, 52'h0, c2);
      ok(c2 > c1);
      pins(1'b0, 1'b1);
      idle(130);
      apb(1'b0, ADR_ITV, 32'h0, 1'b0, 1'b0, 32'h0, i3);
      i1 = (32'h00abcd - i3) & 32'h00ffffff;
      ok(i1 >= 32'h2 && i1 <= 32'h3);
      // Running: both counters step on the same microsecond
      w52(ADR_TMR_HI, 52'h0_0001_0000_0000);
      r52(ADR_TOD_HI, 1'b0, 52'h0, c1);
      k1 = cyc;
      r52(ADR_TMR_HI, 1'b0, 52'h0, t1);
      idle(200);
      r52(ADR_TOD_HI, 1'b0, 52'h0, c2);
      k2 = cyc;
      r52(ADR_TMR_HI, 1'b0, 52'h0, t2);
      dc = int'(c2 - c1);
      dt = int'(t1 - t2);
      ok(dc * US <= k2 - k1 + US && dc * US + US >= k2 - k1);
      ok(dc - dt >= -1 && dc - dt <= 1);
      // Comparator uses all bits, then timer runs negative
      wr(ADR_CTRL, 32'h1, 1'b0);
      w52(ADR_TOD_HI, 52'h0_0001_0000_0000);
      w52(ADR_CMP_HI, 52'h0_0000_ffff_ffff);
      w52(ADR_TMR_HI, 52'h2);
      idle(30);
      ok(cc_pend === 1'b1);
      ok(tmr_pend === 1'b1);
      masks(1'b1, 1'b1);
      w52(ADR_TMR_HI, 52'h0_0010_0000_0000);
      idle(3);
      ok(tmr_pend === 1'b0);
      ok(ext_int === 1'b1);
      masks(1'b1, 1'b0);
      w52(ADR_CMP_HI, 52'h0_0001_0010_0000);
      idle(3);
      ok(cc_pend === 1'b0);
      ok(ext_int === 1'b0);
      idle(5);
      chk(52'(q.size()), 52'h0);
      print_verdict();
   end

   // Global guard against a hang anywhere in the sequence
   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      print_verdict();
   end
endmodule

/* verilog/ctf_pkg.sv */
// Shared constants and types of the processor timing facilities
package ctf_pkg;

   // ************************************************************
   // Time base
   // ************************************************************
   localparam int CLK_NS = 50; // 20 MHz system clock
   localparam int US_NS = 1000; // One time-of-day unit
   localparam int US_CYC = (US_NS + CLK_NS - 1) / CLK_NS;
   localparam real ITV_MS = 3.33; // Interval timer resolution
   localparam int ITV_CYC = int'(ITV_MS * 1.0e6 / CLK_NS);

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int AW = 8;
   localparam int TOD_W = 52; // Bit 0 of the doc is the MSB here
   localparam int HI_W = TOD_W - 32;
   localparam int ITV_W = 24; // 2^24 steps of 3.33 ms: about 15.5 h

   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [AW-1:0] ADR_CTRL = 8'h00;
   localparam logic [AW-1:0] ADR_CMD = 8'h04;
   localparam logic [AW-1:0] ADR_TOD_HI = 8'h08;
   localparam logic [AW-1:0] ADR_TOD_LO = 8'h0c;
   localparam logic [AW-1:0] ADR_CMP_HI = 8'h10;
   localparam logic [AW-1:0] ADR_CMP_LO = 8'h14;
   localparam logic [AW-1:0] ADR_TMR_HI = 8'h18;
   localparam logic [AW-1:0] ADR_TMR_LO = 8'h1c;
   localparam logic [AW-1:0] ADR_STAT = 8'h20;
   localparam logic [AW-1:0] ADR_ITV = 8'h24;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int CTL_SUP = 0; // Supervisor state
   localparam int CTL_EXT = 1; // Status-word external summary mask
   localparam int CTL_CCM = 2; // Comparator subclass mask
   localparam int CTL_TMM = 3; // CPU-timer subclass mask
   localparam int CTL_W = 4;
   localparam logic [CTL_W-1:0] CTRL_RST = 4'h0;
   localparam int CMD_IPL = 0; // initial_program_load pulse
   localparam int CMD_IPR = 1; // Initial program reset pulse
   localparam int PIN_STOP = 0; // Index in the synchronised pin vector
   localparam int PIN_SW = 1;
   localparam logic [TOD_W-1:0] TIME_RST = 52'h0;
   localparam logic [ITV_W-1:0] ITV_RST = 24'h0;

   // Bus answer states, one-hot
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_RESP = 2'b10
   } ctf_bus_t;

endpackage

/* verilog/ctf_timing.sv */
// Time-of-day counter, comparator, CPU timer and interval timer on APB
//
// Overview of operation
// R1 - 52-bit time-of-day counter steps once per microsecond and wraps.
// R2 - Time of day is loaded only in supervisor state with switch held.
// R3 - Store-clock returns the present time-of-day value to the program.
// R4 - Time of day keeps counting while the system is stopped.
// R5 - Comparator has time-of-day format and clears on initial_program_load.
// R6 - Privileged accesses load the comparator and read it back.
// R7 - External interruption when time of day exceeds comparator, both masks on.
// R8 - Comparison uses all 52 bits of both values.
// R9 - Masked comparator request stays pending only while the condition holds.
// R10 - CPU timer has time-of-day layout with its top bit as sign.
// R11 - CPU timer and time of day step from one common microsecond tick.
// R12 - CPU timer clears to zero on initial program reset.
// R13 - Privileged accesses load the CPU timer and read it back.
// R14 - CPU timer decrements every microsecond while running or waiting.
// R15 - CPU timer holds its value while the system is stopped.
// R16 - Timer interruption presented as long as the timer is negative.
// R17 - Loading a positive timer value withdraws the pending timer request.
// R18 - Interval timer word steps at 3.33 ms resolution, about 15.5 h span.
// R19 - Interval timer is not updated while the system is stopped.
// R20 - Comparator and timer accesses in problem state fail with an error.
// R21 - Comparator and timer requests are pending independently.
module ctf_timing #(
   parameter int US_CYC_P = ctf_pkg::US_CYC,
   parameter int ITV_CYC_P = ctf_pkg::ITV_CYC
) (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ctf_pkg::AW-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic sec_sw_in,
   input wire logic sys_stop_in,
   output logic ext_int_out,
   output logic cc_pend_out,
   output logic tmr_pend_out
);
   import ctf_pkg::*;

   localparam int UW = $clog2(US_CYC_P);
   localparam int IW = $clog2(ITV_CYC_P);

   // Both dividers need at least two states to give a one-cycle tick
   if (US_CYC_P < 2 || ITV_CYC_P < 2) begin : g_chk
      $error("ctf_timing: divider counts must be at least 2");
   end

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_b_in);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [1:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, lvl_q, lvl_d;
   logic stop;

   // A level counts only once the second and third stages agree
   always_comb begin
      s1_d = {sec_sw_in, sys_stop_in};
      s2_d = s1_q;
      s3_d = s2_q;
      lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
   end

   // Synchroniser registers
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         s1_q <= 2'h0;
         s2_q <= 2'h0;
         s3_q <= 2'h0;
         lvl_q <= 2'h0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         lvl_q <= lvl_d;
      end
   end

   assign stop = lvl_q[PIN_STOP];

   // ************************************************************
   // APB slave
   // ************************************************************
   ctf_bus_t bus_q, bus_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic [31:0] snap_q, snap_d;
   logic [HI_W-1:0] stage_q, stage_d;
   logic [CTL_W-1:0] ctrl_q, ctrl_d;
   logic [TOD_W-1:0] tod_q, cmp_q, tmr_q;
   logic [ITV_W-1:0] itv_q;
   logic cc_pend_q, tmr_pend_q, ext_q;
   logic sup, acc_err, wr, hi_wr;
   logic tod_ld, cmp_ld, tmr_ld, itv_wr, initial_program_load, ipr;
   logic [31:0] rdata;
   logic [TOD_W-1:0] ld_val;

   // Decode: error and read data for the addressed register
   always_comb begin
      sup = ctrl_q[CTL_SUP];
      acc_err = 1'b0;
      rdata = 32'h0;
      case (paddr_in)
         ADR_CTRL: rdata = 32'(ctrl_q);
         ADR_CMD: rdata = 32'h0; // Pulses only, nothing to read
         ADR_TOD_HI: begin
            acc_err = pwrite_in & ~(sup & lvl_q[PIN_SW]); // R2
            rdata = 32'(tod_q[TOD_W-1:32]); // R3
         end
         ADR_TOD_LO: begin
            acc_err = pwrite_in & ~(sup & lvl_q[PIN_SW]); // R2
            rdata = snap_q; // R3
         end
         ADR_CMP_HI: begin
            acc_err = ~sup; // R20
            rdata = 32'(cmp_q[TOD_W-1:32]); // R6
         end
         ADR_CMP_LO: begin
            acc_err = ~sup; // R20
            rdata = cmp_q[31:0]; // R6
         end
         ADR_TMR_HI: begin
            acc_err = ~sup; // R20
            rdata = 32'(tmr_q[TOD_W-1:32]); // R13
         end
         ADR_TMR_LO: begin
            acc_err = ~sup; // R20
            rdata = snap_q; // R13
         end
         ADR_STAT: rdata = 32'({lvl_q, tmr_pend_q, cc_pend_q});
         ADR_ITV: rdata = 32'(itv_q);
         default: acc_err = 1'b1;
      endcase
      if (acc_err) begin
         rdata = 32'h0;
      end
   end

   // Effects take place only at the edge where pready is seen high
   always_comb begin
      wr = (bus_q == BUS_RESP) & psel_in & penable_in & pwrite_in & ~pslverr_q;
      hi_wr = wr & (paddr_in == ADR_TOD_HI || paddr_in == ADR_CMP_HI ||
                    paddr_in == ADR_TMR_HI);
      tod_ld = wr & (paddr_in == ADR_TOD_LO);
      cmp_ld = wr & (paddr_in == ADR_CMP_LO);
      tmr_ld = wr & (paddr_in == ADR_TMR_LO);
      itv_wr = wr & (paddr_in == ADR_ITV);
      initial_program_load = wr & (paddr_in == ADR_CMD) & pwdata_in[CMD_IPL];
      // A load also performs the program reset
      ipr = wr & (paddr_in == ADR_CMD) & (pwdata_in[CMD_IPR] | pwdata_in[CMD_IPL]);
      ld_val = {stage_q, pwdata_in};
      ctrl_d = (wr & (paddr_in == ADR_CTRL)) ? pwdata_in[CTL_W-1:0] : ctrl_q;
   end

   // Bus sequencing: one wait state, then a one-cycle answer
   always_comb begin
      bus_d = bus_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      prdata_d = 32'h0;
      snap_d = snap_q;
      stage_d = stage_q;
      case (bus_q)
         BUS_IDLE: begin
            if (psel_in && penable_in) begin
               bus_d = BUS_RESP;
               pready_d = 1'b1;
               pslverr_d = acc_err;
               prdata_d = pwrite_in ? 32'h0 : rdata;
               // Reading the upper half freezes the lower one coherently
               if (!pwrite_in && !acc_err && paddr_in == ADR_TOD_HI) begin
                  snap_d = tod_q[31:0]; // R3
               end
               if (!pwrite_in && !acc_err && paddr_in == ADR_TMR_HI) begin
                  snap_d = tmr_q[31:0]; // R13
               end
            end
         end
         BUS_RESP: begin
            bus_d = BUS_IDLE;
            if (hi_wr) begin
               stage_d = pwdata_in[HI_W-1:0];
            end
         end
         default: bus_d = BUS_IDLE;
      endcase
   end

   // Bus registers
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         bus_q <= BUS_IDLE;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
         snap_q <= 32'h0;
         stage_q <= 20'h0;
         ctrl_q <= CTRL_RST;
      end else begin
         bus_q <= bus_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
         snap_q <= snap_d;
         stage_q <= stage_d;
         ctrl_q <= ctrl_d;
      end
   end

   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
   assign prdata_out = prdata_q;

   sequence s_setup;
      psel_in && penable_in && bus_q == BUS_IDLE;
   endsequence

   sequence s_refused;
      pready_out && pslverr_out;
   endsequence

   property p_priv_err;
      (s_setup and (!ctrl_q[CTL_SUP] && paddr_in[7:4] == 4'h1)) |=> s_refused;
   endproperty
   a_priv_err: assert property (p_priv_err) // R20
      else $error("privileged access in problem state not refused");

   property p_tod_guard;
      tod_ld |-> (ctrl_q[CTL_SUP] && lvl_q[PIN_SW]);
   endproperty
   a_tod_guard: assert property (p_tod_guard) // R2
      else $error("time of day loaded without supervisor and switch");

   // ************************************************************
   // Counters
   // ************************************************************
   logic [UW-1:0] us_q, us_d;
   logic [IW-1:0] ivc_q, ivc_d;
   logic [TOD_W-1:0] tod_d, cmp_d, tmr_d;
   logic [ITV_W-1:0] itv_d;
   logic us_tick, itv_tick;

   // Next values; a software load wins over a same-cycle step
   always_comb begin
      us_tick = (us_q == UW'(US_CYC_P - 1)); // R11
      us_d = us_tick ? '0 : us_q + UW'(1);
      // Not gated by stop: time of day runs through stops
      tod_d = tod_ld ? ld_val : tod_q + (us_tick ? 52'h1 : 52'h0); // R1 R4
      cmp_d = cmp_q;
      if (initial_program_load) begin
         cmp_d = TIME_RST; // R5
      end else if (cmp_ld) begin
         cmp_d = ld_val; // R6
      end
      tmr_d = tmr_q;
      if (ipr) begin
         tmr_d = TIME_RST; // R12
      end else if (tmr_ld) begin
         tmr_d = ld_val; // R13
      end else if (us_tick && !stop) begin
         tmr_d = tmr_q - 52'h1; // R11 R14 R15
      end
      // The interval divider freezes too, so no partial tick is lost
      itv_tick = !stop && (ivc_q == IW'(ITV_CYC_P - 1)); // R19
      ivc_d = stop ? ivc_q : (itv_tick ? '0 : ivc_q + IW'(1)); // R18
      itv_d = itv_q;
      if (itv_wr) begin
         itv_d = pwdata_in[ITV_W-1:0];
      end else if (itv_tick) begin
         itv_d = itv_q - 24'h1; // R18
      end
   end

   // Counter registers
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         us_q <= '0;
         ivc_q <= '0;
         tod_q <= TIME_RST;
         cmp_q <= TIME_RST;
         tmr_q <= TIME_RST;
         itv_q <= ITV_RST;
      end else begin
         us_q <= us_d;
         ivc_q <= ivc_d;
         tod_q <= tod_d;
         cmp_q <= cmp_d;
         tmr_q <= tmr_d;
         itv_q <= itv_d;
      end
   end

   property p_tod_step;
      (us_tick && !tod_ld) |=> tod_q == $past(tod_q) + 52'h1;
   endproperty
   a_tod_step: assert property (p_tod_step) // R1
      else $error("time of day did not step on the microsecond");

   property p_tod_stopped;
      (stop && us_tick && !tod_ld) |=> tod_q != $past(tod_q);
   endproperty
   a_tod_stopped: assert property (p_tod_stopped) // R4
      else $error("time of day halted while stopped");

   property p_cmp_ipl;
      initial_program_load |=> cmp_q == TIME_RST;
   endproperty
   a_cmp_ipl: assert property (p_cmp_ipl) // R5
      else $error("comparator not cleared by load");

   property p_tmr_ipr;
      ipr |=> tmr_q == TIME_RST;
   endproperty
   a_tmr_ipr: assert property (p_tmr_ipr) // R12
      else $error("timer not cleared by program reset");

   property p_tmr_dec;
      (us_tick && !stop && !tmr_ld && !ipr) |=> tmr_q == $past(tmr_q) - 52'h1;
   endproperty
   a_tmr_dec: assert property (p_tmr_dec) // R14
      else $error("timer did not decrement");

   property p_tmr_hold;
      (stop && !tmr_ld && !ipr) |=> $stable(tmr_q);
   endproperty
   a_tmr_hold: assert property (p_tmr_hold) // R15
      else $error("timer moved while stopped");

   property p_itv_hold;
      (stop && !itv_wr) |=> $stable(itv_q);
   endproperty
   a_itv_hold: assert property (p_itv_hold) // R19
      else $error("interval timer moved while stopped");

   // ************************************************************
   // Interruption requests
   // ************************************************************
   logic cc_cond, tmr_neg, cc_pend_d, tmr_pend_d, ext_d;

   // Requests are levels: each follows its own condition, never latched
   always_comb begin
      cc_cond = tod_q > cmp_q; // R8
      tmr_neg = tmr_q[TOD_W-1]; // R10
      cc_pend_d = cc_cond; // R9 R21
      tmr_pend_d = tmr_neg; // R16 R17 R21
      ext_d = ctrl_q[CTL_EXT] &
              ((cc_cond & ctrl_q[CTL_CCM]) | (tmr_neg & ctrl_q[CTL_TMM])); // R7 R16
   end

   // Request registers
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         cc_pend_q <= 1'b0;
         tmr_pend_q <= 1'b0;
         ext_q <= 1'b0;
      end else begin
         cc_pend_q <= cc_pend_d;
         tmr_pend_q <= tmr_pend_d;
         ext_q <= ext_d;
      end
   end

   assign cc_pend_out = cc_pend_q;
   assign tmr_pend_out = tmr_pend_q;
   assign ext_int_out = ext_q;

   property p_cc_int;
      (ctrl_q[CTL_EXT] && ctrl_q[CTL_CCM] && tod_q > cmp_q) |=> ext_int_out;
   endproperty
   a_cc_int: assert property (p_cc_int) // R7
      else $error("comparator interruption missing");

   property p_cc_drop;
      (tod_q <= cmp_q) |=> !cc_pend_out;
   endproperty
   a_cc_drop: assert property (p_cc_drop) // R9
      else $error("comparator request outlived its condition");

   property p_tmr_int;
      (ctrl_q[CTL_EXT] && ctrl_q[CTL_TMM] && tmr_q[TOD_W-1]) |=> ext_int_out;
   endproperty
   a_tmr_int: assert property (p_tmr_int) // R16
      else $error("timer interruption missing while negative");

   property p_tmr_withdraw;
      (tmr_ld && !ld_val[TOD_W-1] && ld_val != TIME_RST) |=> ##1 !tmr_pend_out;
   endproperty
   a_tmr_withdraw: assert property (p_tmr_withdraw) // R17
      else $error("positive timer load left request pending");

   property p_both_pend;
      (cc_cond && tmr_neg) |=> (cc_pend_out && tmr_pend_out);
   endproperty
   a_both_pend: assert property (p_both_pend) // R21
      else $error("one request hid the other");

endmodule
